//--- crfsh_regs.svh
/*
  Register offsets, field positions, reset values and frame counts of the
  receive filter with sleep and halt control.
  Assumes 32-bit APB data and a 12-bit byte address.
*/
`ifndef CRFSH_REGS_SVH
`define CRFSH_REGS_SVH
`define CRFSH_OFF_MCTL 12'h000
`define CRFSH_OFF_IFLG 12'h004
`define CRFSH_OFF_IMSK 12'h008
`define CRFSH_OFF_RXC 12'h00C
`define CRFSH_OFF_RFP 12'h010
`define CRFSH_OFF_UOW 12'h014
`define CRFSH_OFF_MBIM 12'h018
`define CRFSH_OFF_DIR 12'h01C
`define CRFSH_OFF_DCM 12'h020
`define CRFSH_MB_PAGE 4'h1
`define CRFSH_MCTL_HALT 1
`define CRFSH_MCTL_SLEEP 5
`define CRFSH_MCTL_WAKE 7
`define CRFSH_MCTL_SLEEP_ST 8
`define CRFSH_MCTL_HALT_ST 9
`define CRFSH_IFLG_RX 1
`define CRFSH_IFLG_RMT 2
`define CRFSH_IFLG_UOW 9
`define CRFSH_IFLG_BUS 12
`define CRFSH_DIR_RST 16'h0001
`define CRFSH_IMSK_RST 16'h0000
`define CRFSH_IDLE_BITS 4'hB
`define CRFSH_EOF_BITS 4'hA
`define CRFSH_STUFF_RUN 3'h5
`define CRFSH_CRC_POLY 15'h4599
`define CRFSH_POS_ID_END 7'h0B
`define CRFSH_POS_RTR 7'h0C
`define CRFSH_POS_IDE 7'h0D
`define CRFSH_POS_DLC_END 7'h12
`define CRFSH_POS_DATA 7'h13
`define CRFSH_CRC_TAIL 7'h0E
`endif

//--- crfsh_pkg.sv
/*
  Types of the receive filter block: parser states and the message carrier.
  Assumes the constants header is included by the design file.
*/
package crfsh_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_FIELD = 3'b010,
    ST_CRCDEL = 3'b011,
    ST_ACK = 3'b100,
    ST_ACKDEL = 3'b101,
    ST_EOF = 3'b110
  } crfsh_state_e;
  typedef logic [15:0] crfsh_mbv_t;
  typedef struct packed {
    logic [10:0] id;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } crfsh_msg_s;
endpackage : crfsh_pkg

//--- crfsh_top.sv
/*
  Receive side of a 16-mailbox CAN controller: destuffing, crc, ack,
  identifier filter, mailbox store, flags, sleep and halt, APB registers.
  Assumes an external bit timer gives bit_en_i at each sample point and an
  external transceiver; standard 11-bit frames only.
*/
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "crfsh_regs.svh"
module crfsh_top import crfsh_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bit_en_i,
  input wire logic rx_i,
  output logic tx_o,
  output logic irq_o,
  output logic sleep_o,
  output logic halt_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  crfsh_state_e st_r;
  logic [6:0] cnt_r, end_r, didx;
  logic [3:0] rc_r;
  logic [2:0] run_r;
  logic last_r, crc_ok_r, ackn_r;
  logic [14:0] crc_r;
  crfsh_msg_s frm_r;
  crfsh_msg_s mb_r [16];
  crfsh_mbv_t rxc_r, rfp_r, uow_r, mbim_r, dir_r, hit_c, store_vec;
  logic [15:0] iflg_r, imsk_r;
  logic [10:0] dcm_r;
  logic halt_req_r, sleep_req_r, wake_sel_r, sleep_r, halt_r, discard_r;
  logic wr_c, m0_c, found_c, frame_done, store_en, act_c, wake_c, mb_acc, mapped_c;
  logic [31:0] prdata_r;

  // crc-15 step on one destuffed bit
  function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
    logic fb;
    fb = b ^ c[14];
    return {c[13:0], 1'b0} ^ (fb ? `CRFSH_CRC_POLY : 15'h0000);
  endfunction : crc_step

  // index of the last crc bit from rtr and length code
  function automatic logic [6:0] end_pos(input logic rtr, input logic [3:0] dlc);
    logic [3:0] n;
    n = rtr ? 4'h0 : ((dlc > 4'h8) ? 4'h8 : dlc);
    return `CRFSH_POS_DATA + `CRFSH_CRC_TAIL + {n, 3'b000};
  endfunction : end_pos

  // APB write strobe to one register
  function automatic logic wr_hit(input logic [11:0] off);
    return wr_c && (paddr_i == off);
  endfunction : wr_hit

  // APB handshake: zero wait states
  assign wr_c = psel_i && penable_i && pwrite_i;
  assign pready_o = 1'b1;
  assign mb_acc = (paddr_i[11:8] == `CRFSH_MB_PAGE) && (paddr_i[3:2] != 2'b11);
  assign mapped_c = mb_acc || (paddr_i[11:0] <= `CRFSH_OFF_DCM && paddr_i[1:0] == 2'b00);
  assign pslverr_o = psel_i && penable_i && !mapped_c;
  assign prdata_o = prdata_r;
  assign tx_o = ackn_r;
  assign sleep_o = sleep_r;
  assign halt_o = halt_r;
  assign didx = cnt_r - `CRFSH_POS_DATA;

  // bit-level frame parser with destuffing and crc
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      cnt_r <= 7'h00;
      end_r <= 7'h7F;
      rc_r <= 4'h0;
      run_r <= 3'h0;
      last_r <= 1'b1;
      crc_r <= 15'h0000;
      crc_ok_r <= 1'b0;
      ackn_r <= 1'b1;
      frm_r <= '0;
    end else if (sleep_r || halt_r) begin
      st_r <= ST_IDLE;
      rc_r <= 4'h0;
      ackn_r <= 1'b1;
    end else if (bit_en_i) begin
      unique case (st_r)
        ST_IDLE: begin
          if (!rx_i) begin
            rc_r <= 4'h0;
          end else if (rc_r == `CRFSH_IDLE_BITS - 4'h1) begin
            st_r <= ST_WAIT;
          end else begin
            rc_r <= rc_r + 4'h1;
          end
        end
        ST_WAIT: begin
          if (!rx_i) begin
            st_r <= ST_FIELD;
            cnt_r <= 7'h01;
            end_r <= 7'h7F;
            run_r <= 3'h1;
            last_r <= 1'b0;
            crc_r <= 15'h0000;
          end
        end
        ST_FIELD: begin
          if (run_r == `CRFSH_STUFF_RUN) begin
            // stuff bit: must differ, not counted
            if (rx_i == last_r) begin
              st_r <= ST_IDLE;
              rc_r <= 4'h0;
            end
            run_r <= 3'h1;
            last_r <= rx_i;
          end else begin
            run_r <= (rx_i == last_r) ? run_r + 3'h1 : 3'h1;
            last_r <= rx_i;
            crc_r <= crc_step(crc_r, rx_i);
            cnt_r <= cnt_r + 7'h01;
            if (cnt_r <= `CRFSH_POS_ID_END) begin
              frm_r.id <= {frm_r.id[9:0], rx_i};
            end
            if (cnt_r == `CRFSH_POS_RTR) begin
              frm_r.rtr <= rx_i;
            end
            if (cnt_r == `CRFSH_POS_IDE && rx_i) begin
              st_r <= ST_IDLE; // extended frames are not taken
              rc_r <= 4'h0;
            end
            if (cnt_r > `CRFSH_POS_IDE + 7'h01 && cnt_r <= `CRFSH_POS_DLC_END) begin
              frm_r.dlc <= {frm_r.dlc[2:0], rx_i};
            end
            if (cnt_r == `CRFSH_POS_DLC_END) begin
              end_r <= end_pos(frm_r.rtr, {frm_r.dlc[2:0], rx_i});
            end
            if (cnt_r >= `CRFSH_POS_DATA && cnt_r < end_r - `CRFSH_CRC_TAIL) begin
              frm_r.data[~didx[5:0]] <= rx_i;
            end
            if (cnt_r == end_r) begin
              st_r <= ST_CRCDEL;
            end
          end
        end
        ST_CRCDEL: begin
          if (run_r == `CRFSH_STUFF_RUN) begin
            // trailing stuff bit after the last crc bit, not the delimiter
            run_r <= 3'h1;
            if (rx_i == last_r) begin
              st_r <= ST_IDLE;
            end
          end else begin
            st_r <= rx_i ? ST_ACK : ST_IDLE;
            crc_ok_r <= rx_i && (crc_r == 15'h0000);
            ackn_r <= !(rx_i && (crc_r == 15'h0000));
          end
          rc_r <= 4'h0;
        end
        ST_ACK: begin
          ackn_r <= 1'b1;
          st_r <= ST_ACKDEL;
        end
        ST_ACKDEL: begin
          st_r <= rx_i ? ST_EOF : ST_IDLE;
          rc_r <= 4'h0;
        end
        ST_EOF: begin
          if (!rx_i) begin
            st_r <= ST_IDLE;
            rc_r <= 4'h0;
          end else if (rc_r == `CRFSH_EOF_BITS - 4'h1) begin
            st_r <= ST_WAIT;
          end else begin
            rc_r <= rc_r + 4'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  a_ack_good_crc: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(ackn_r) |-> $past(st_r) == ST_CRCDEL && $past(crc_r) == 15'h0000)
    else $error("ack driven without good crc");

  // identifier filter: mailbox 0 masked, then first exact match of receive mailboxes 1-15, skipped when mailbox 0 hits with a zero mask
  always_comb begin
    hit_c = '0;
    found_c = 1'b0;
    m0_c = ((frm_r.id ^ mb_r[0].id) & ~dcm_r) == 11'h000;
    hit_c[0] = m0_c;
    for (int i = 1; i < 16; i++) begin
      if (!found_c && dir_r[i] && frm_r.id == mb_r[i].id && (!m0_c || dcm_r != 11'h000)) begin
        hit_c[i] = 1'b1;
        found_c = 1'b1;
      end
    end
  end

  // store strobe at the ack delimiter of a good frame
  assign frame_done = bit_en_i && st_r == ST_ACKDEL && rx_i && crc_ok_r && !sleep_r && !halt_r;
  assign store_en = frame_done && !discard_r;
  assign store_vec = store_en ? hit_c : '0;

  a_one_upper_mb: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(store_vec[15:1]))
    else $error("message stored in two upper mailboxes");
  a_dir_rx_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (store_vec & ~dir_r & 16'hFFFE) == 16'h0000)
    else $error("stored into a transmit mailbox");
  a_halt_no_store: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_r |-> ##1 (store_vec == 16'h0000) [*3])
    else $error("store while halted");

  // mailbox storage: receive store wins over a same-cycle write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        mb_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (store_vec[i]) begin
          mb_r[i].id <= frm_r.id;
          mb_r[i].rtr <= frm_r.rtr;
          mb_r[i].dlc <= frm_r.dlc;
          if (!frm_r.rtr) begin
            mb_r[i].data <= frm_r.data;
          end
        end else if (wr_c && mb_acc && paddr_i[7:4] == 4'(i)) begin
          unique case (paddr_i[3:2])
            2'b00: {mb_r[i].dlc, mb_r[i].rtr, mb_r[i].id} <= pwdata_i[15:0];
            2'b01: mb_r[i].data[63:32] <= pwdata_i;
            default: mb_r[i].data[31:0] <= pwdata_i;
          endcase
        end
      end
    end
  end

  // status flags: hardware set wins over write-one clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxc_r <= '0;
      rfp_r <= '0;
      uow_r <= '0;
      iflg_r <= 16'h0000;
    end else begin
      rxc_r <= (rxc_r & ~(wr_hit(`CRFSH_OFF_RXC) ? pwdata_i[15:0] : 16'h0000)) | store_vec;
      rfp_r <= (rfp_r & ~(wr_hit(`CRFSH_OFF_RFP) ? pwdata_i[15:0] : 16'h0000))
               | (store_vec & {16{frm_r.rtr}});
      uow_r <= (uow_r & ~(wr_hit(`CRFSH_OFF_UOW) ? pwdata_i[15:0] : 16'h0000))
               | (store_vec & rxc_r);
      iflg_r <= iflg_r & ~(wr_hit(`CRFSH_OFF_IFLG) ? pwdata_i[15:0] : 16'h0000);
      if (|(store_vec & mbim_r) && !frm_r.rtr) begin
        iflg_r[`CRFSH_IFLG_RX] <= 1'b1;
      end
      if (|(store_vec & mbim_r) && frm_r.rtr) begin
        iflg_r[`CRFSH_IFLG_RMT] <= 1'b1;
      end
      if (|(store_vec & rxc_r)) begin
        iflg_r[`CRFSH_IFLG_UOW] <= 1'b1;
      end
      if (act_c) begin
        iflg_r[`CRFSH_IFLG_BUS] <= 1'b1;
      end
    end
  end

  // request line gated by the global mask
  assign irq_o = |(iflg_r & imsk_r);

  a_remote_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    store_en && hit_c[0] && frm_r.rtr |=> rfp_r[0])
    else $error("remote flag not set");
  a_overwrite_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    |(store_vec & rxc_r) |=> |(uow_r & $past(store_vec)))
    else $error("overwrite flag not set");
  a_rx_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(iflg_r[`CRFSH_IFLG_RX]) |-> $past(|(store_vec & mbim_r)))
    else $error("receive irq without mailbox enable");
  a_rx_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    store_en && m0_c |=> rxc_r[0])
    else $error("receive flag of mailbox 0 not set");

  // sleep, wake-up and halt control
  assign act_c = sleep_r && !rx_i;
  assign wake_c = act_c && wake_sel_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      halt_req_r <= 1'b0;
      sleep_req_r <= 1'b0;
      wake_sel_r <= 1'b0;
      sleep_r <= 1'b0;
      halt_r <= 1'b0;
      discard_r <= 1'b0;
    end else begin
      if (wr_hit(`CRFSH_OFF_MCTL)) begin
        halt_req_r <= pwdata_i[`CRFSH_MCTL_HALT];
        sleep_req_r <= pwdata_i[`CRFSH_MCTL_SLEEP];
        wake_sel_r <= pwdata_i[`CRFSH_MCTL_WAKE];
      end else if (wake_c) begin
        sleep_req_r <= 1'b0;
      end
      if (sleep_r) begin
        sleep_r <= sleep_req_r && !wake_c;
      end else if (sleep_req_r && st_r == ST_WAIT) begin
        sleep_r <= 1'b1;
      end
      if (!halt_req_r) begin
        halt_r <= 1'b0;
      end else if (st_r == ST_WAIT) begin
        halt_r <= 1'b1;
      end
      if (wake_c) begin
        discard_r <= 1'b1;
      end else if (frame_done || st_r == ST_WAIT) begin
        discard_r <= 1'b0; // only the waking frame is dropped
      end
    end
  end

  a_sleep_at_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(sleep_r) |-> $past(st_r) == ST_WAIT)
    else $error("sleep entered while bus busy");
  a_wake_relearn: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(sleep_r) |-> st_r == ST_IDLE && rc_r == 4'h0)
    else $error("resumed without recessive count");
  a_bus_wake_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    discard_r |-> store_vec == 16'h0000)
    else $error("first frame after wake stored");

  // configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      imsk_r <= `CRFSH_IMSK_RST;
      mbim_r <= '0;
      dir_r <= `CRFSH_DIR_RST;
      dcm_r <= 11'h000;
    end else begin
      if (wr_hit(`CRFSH_OFF_IMSK)) begin
        imsk_r <= pwdata_i[15:0];
      end
      if (wr_hit(`CRFSH_OFF_MBIM)) begin
        mbim_r <= pwdata_i[15:0];
      end
      if (wr_hit(`CRFSH_OFF_DIR)) begin
        dir_r <= {pwdata_i[15:1], 1'b1};
      end
      if (wr_hit(`CRFSH_OFF_DCM)) begin
        dcm_r <= pwdata_i[10:0];
      end
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_r <= 32'h0000_0000;
      if (mb_acc) begin
        unique case (paddr_i[3:2])
          2'b00: prdata_r <= {16'h0000, mb_r[paddr_i[7:4]].dlc, mb_r[paddr_i[7:4]].rtr, mb_r[paddr_i[7:4]].id};
          2'b01: prdata_r <= mb_r[paddr_i[7:4]].data[63:32];
          default: prdata_r <= mb_r[paddr_i[7:4]].data[31:0];
        endcase
      end else begin
        unique case (paddr_i)
          `CRFSH_OFF_MCTL: prdata_r <= {22'h000000, halt_r, sleep_r, wake_sel_r, 1'b0, sleep_req_r, 3'h0,
                                        halt_req_r, 1'b0};
          `CRFSH_OFF_IFLG: prdata_r <= {16'h0000, iflg_r};
          `CRFSH_OFF_IMSK: prdata_r <= {16'h0000, imsk_r};
          `CRFSH_OFF_RXC: prdata_r <= {16'h0000, rxc_r};
          `CRFSH_OFF_RFP: prdata_r <= {16'h0000, rfp_r};
          `CRFSH_OFF_UOW: prdata_r <= {16'h0000, uow_r};
          `CRFSH_OFF_MBIM: prdata_r <= {16'h0000, mbim_r};
          `CRFSH_OFF_DIR: prdata_r <= {16'h0000, dir_r};
          `CRFSH_OFF_DCM: prdata_r <= {21'h000000, dcm_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : crfsh_top

//--- crfsh_node.sv
/*
  can node model: sends standard frames with stuffing and crc, and makes
  the sample-point pulse. assumes a wired-and bus with the block's tx.
*/
`timescale 1ns/1ps
`include "crfsh_regs.svh"
module crfsh_node (
  input wire logic clk_i,
  input wire logic tx_i,
  output logic bus_o,
  output logic bit_en_o
);
  logic lvl = 1'b1;
  logic last = 1'b1;
  logic ack_seen = 1'b0;
  logic [1:0] cnt = 2'h0;
  int run = 0;
  // recessive unless some party drives dominant
  assign bus_o = lvl & tx_i;
  assign bit_en_o = (cnt == 2'h3);
  // bit timer: one sample point every four clocks
  always_ff @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
  end
  // new level right after a sample edge, held to the next one
  task automatic put(input logic b);
    @(posedge clk_i iff bit_en_o);
    lvl <= b;
  endtask : put
  task automatic idle(input int n);
    repeat (n) put(1'b1);
  endtask : idle
  // complement inserted after five equal bits
  task automatic stb(input logic b);
    put(b);
    run = (b == last) ? run + 1 : 1;
    last = b;
    if (run == 5) begin
      put(!b);
      last = !b;
      run = 1;
    end
  endtask : stb
  task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
                      input logic [63:0] d, input logic bad, input int pre);
    logic [82:0] f;
    logic [14:0] crc;
    logic c;
    int n;
    n = (rtr || dlc == 4'h0) ? 0 : (dlc > 4'h8 ? 64 : 8 * dlc);
    f = {1'b0, id, rtr, 2'b00, dlc, d};
    crc = 15'h0000;
    for (int i = 82; i >= 64 - n; i--) begin
      c = f[i] ^ crc[14];
      crc = {crc[13:0], 1'b0} ^ (c ? `CRFSH_CRC_POLY : 15'h0000);
    end
    crc[0] = crc[0] ^ bad;
    idle(pre);
    last = 1'b1;
    run = 0;
    for (int i = 82; i >= 64 - n; i--) stb(f[i]);
    for (int i = 14; i >= 0; i--) stb(crc[i]);
    put(1'b1);  // crc delimiter
    put(1'b1);  // ack slot left recessive for the receiver
    @(negedge clk_i);
    ack_seen = !bus_o;
    idle(11);  // ack delimiter, end of frame, intermission
  endtask : send
endmodule : crfsh_node

//--- crfsh_top_tb.sv
/*
  testbench of the receive filter block: apb master, one task per test.
  assumes the node model on the bus side and a 10 MHz clock.
*/
`timescale 1ns/1ps
`include "crfsh_regs.svh"
module crfsh_top_tb;
  localparam logic [63:0] DAT = 64'h0123456789ABCDEF;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic e;
  logic tx;
  logic irq;
  logic slp;
  logic hlt;
  logic bus;
  logic ben;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  crfsh_top crfsh_top_i (
    .clk_i(clk), .rst_i(rst), .bit_en_i(ben), .rx_i(bus), .tx_o(tx), .irq_o(irq),
    .sleep_o(slp), .halt_o(hlt), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr)
  );
  crfsh_node crfsh_node_i (.clk_i(clk), .tx_i(tx), .bus_o(bus), .bit_en_o(ben));
  // clock
  initial begin
    forever #50 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  // one apb transfer, released after pready, settles to the falling edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk iff pready);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, q);
  endtask : rdc
  function automatic logic [11:0] mb(input int m);
    return 12'h100 + 12'(m * 16);
  endfunction : mb
  task automatic clr();
    wr(`CRFSH_OFF_RXC, 32'hFFFF);
    wr(`CRFSH_OFF_RFP, 32'hFFFF);
    wr(`CRFSH_OFF_UOW, 32'hFFFF);
    wr(`CRFSH_OFF_IFLG, 32'hFFFF);
  endtask : clr
  task automatic sf(input logic [10:0] id, input logic [63:0] d);
    crfsh_node_i.send(id, 1'b0, 4'h4, d, 1'b0, 11);
  endtask : sf
  task automatic ack(input logic x);
    chk("ack", 32'(x), 32'(crfsh_node_i.ack_seen));
  endtask : ack
  task automatic t_regs();
    rdc(`CRFSH_OFF_DIR, 32'h1);
    chk("pready", 32'h1, 32'(pready));
    rdc(`CRFSH_OFF_IMSK, 32'h0);
    rdc(`CRFSH_OFF_MCTL, 32'h0);
    wr(`CRFSH_OFF_DIR, 32'h0);
    rdc(`CRFSH_OFF_DIR, 32'h1);
    apb(1'b0, 12'h10C, 32'h0);
    chk("slverr", 32'h1, 32'(e));
    chk("unmapped", 32'h0, q);
    $display("test regs done");
  endtask : t_regs
  task automatic t_match();
    wr(mb(1), 32'h2AA);
    wr(mb(2), 32'h2AA);
    wr(mb(3), 32'h2AA);
    wr(mb(0), 32'h123);
    wr(`CRFSH_OFF_DIR, 32'hC);
    crfsh_node_i.send(11'h2AA, 1'b0, 4'h8, DAT, 1'b0, 11);
    ack(1'b1);
    rdc(`CRFSH_OFF_RXC, 32'h4);
    rdc(mb(2), 32'h82AA);
    rdc(mb(2) + 12'h4, DAT[63:32]);
    rdc(mb(2) + 12'h8, DAT[31:0]);
    rdc(`CRFSH_OFF_IFLG, 32'h0);
    clr();
    $display("test match done");
  endtask : t_match
  task automatic t_mask();
    wr(mb(0), 32'h2A8);
    wr(`CRFSH_OFF_DCM, 32'h3);
    wr(`CRFSH_OFF_MBIM, 32'h4);
    wr(`CRFSH_OFF_IMSK, 32'h2);
    sf(11'h2AA, DAT);
    rdc(`CRFSH_OFF_RXC, 32'h5);
    rdc(`CRFSH_OFF_IFLG, 32'h2);
    chk("irq", 32'h1, 32'(irq));
    clr();
    chk("irq", 32'h0, 32'(irq));
    sf(11'h2AE, DAT);
    ack(1'b1);
    rdc(`CRFSH_OFF_RXC, 32'h0);
    wr(`CRFSH_OFF_DCM, 32'h0);
    wr(mb(0), 32'h2AA);
    sf(11'h2AA, DAT);
    rdc(`CRFSH_OFF_RXC, 32'h1);
    wr(mb(0), 32'h123);
    clr();
    $display("test mask done");
  endtask : t_mask
  task automatic t_over();
    wr(`CRFSH_OFF_IMSK, 32'h200);
    sf(11'h2AA, {32'h11223344, 32'h0});
    sf(11'h2AA, {32'h55667788, 32'h0});
    rdc(`CRFSH_OFF_UOW, 32'h4);
    rdc(mb(2) + 12'h4, 32'h55667788);
    rdc(`CRFSH_OFF_IFLG, 32'h202);
    chk("irq", 32'h1, 32'(irq));
    wr(`CRFSH_OFF_UOW, 32'h0);
    rdc(`CRFSH_OFF_UOW, 32'h4);
    wr(`CRFSH_OFF_UOW, 32'h4);
    rdc(`CRFSH_OFF_UOW, 32'h0);
    clr();
    $display("test overwrite done");
  endtask : t_over
  task automatic t_remote();
    wr(`CRFSH_OFF_IMSK, 32'h4);
    crfsh_node_i.send(11'h2AA, 1'b1, 4'h3, DAT, 1'b0, 11);
    rdc(`CRFSH_OFF_RFP, 32'h4);
    rdc(mb(2), 32'h3AAA);
    rdc(`CRFSH_OFF_IFLG, 32'h4);
    chk("irq", 32'h1, 32'(irq));
    clr();
    wr(`CRFSH_OFF_MBIM, 32'h0);
    crfsh_node_i.send(11'h2AA, 1'b1, 4'h3, DAT, 1'b0, 11);
    rdc(`CRFSH_OFF_IFLG, 32'h0);
    clr();
    crfsh_node_i.send(11'h2AA, 1'b0, 4'h1, DAT, 1'b1, 11);
    ack(1'b0);
    rdc(`CRFSH_OFF_RXC, 32'h0);
    $display("test remote and crc done");
  endtask : t_remote
  task automatic t_sleep();
    wr(`CRFSH_OFF_IMSK, 32'h1000);
    crfsh_node_i.idle(12);
    wr(`CRFSH_OFF_MCTL, 32'h20);
    crfsh_node_i.idle(2);
    chk("sleep", 32'h1, 32'(slp));
    sf(11'h2AA, DAT);
    chk("sleep", 32'h1, 32'(slp));
    rdc(`CRFSH_OFF_IFLG, 32'h1000);
    chk("irq", 32'h1, 32'(irq));
    rdc(`CRFSH_OFF_RXC, 32'h0);
    clr();
    wr(`CRFSH_OFF_MCTL, 32'h0);
    @(negedge clk);  // mode flag follows the request one cycle later
    chk("sleep", 32'h0, 32'(slp));
    crfsh_node_i.send(11'h2AA, 1'b0, 4'h0, DAT, 1'b0, 2);
    ack(1'b0);
    rdc(`CRFSH_OFF_RXC, 32'h0);
    wr(`CRFSH_OFF_MCTL, 32'hA0);
    crfsh_node_i.idle(2);
    chk("sleep", 32'h1, 32'(slp));
    sf(11'h2AA, DAT);
    chk("sleep", 32'h0, 32'(slp));
    rdc(`CRFSH_OFF_MCTL, 32'h80);
    rdc(`CRFSH_OFF_RXC, 32'h0);
    sf(11'h2AA, DAT);
    rdc(`CRFSH_OFF_RXC, 32'h4);
    sf(11'h2AA, DAT);
    rdc(`CRFSH_OFF_UOW, 32'h4);
    clr();
    wr(`CRFSH_OFF_MCTL, 32'h0);
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_halt();
    crfsh_node_i.idle(12);
    wr(`CRFSH_OFF_MCTL, 32'h2);
    crfsh_node_i.idle(2);
    chk("halt", 32'h1, 32'(hlt));
    rdc(`CRFSH_OFF_MCTL, 32'h202);
    wr(mb(2), 32'h155);
    rdc(mb(2), 32'h155);
    sf(11'h155, DAT);
    rdc(`CRFSH_OFF_RXC, 32'h0);
    wr(`CRFSH_OFF_MCTL, 32'h0);
    @(negedge clk);  // mode flag follows the request one cycle later
    chk("halt", 32'h0, 32'(hlt));
    sf(11'h155, DAT);
    rdc(`CRFSH_OFF_RXC, 32'h4);
    $display("test halt done");
  endtask : t_halt
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_match();
    t_mask();
    t_over();
    t_remote();
    t_sleep();
    t_halt();
    complete_run();
  end
endmodule : crfsh_top_tb
